// ---- include/dpr_regs.svh ----
// Purpose: register offsets, field positions and reset values of the
//          dscp priority remap table
// Assumes: byte-wide registers on a 16-bit byte address
// Notes:   definitions only
`ifndef DPR_REGS_SVH
`define DPR_REGS_SVH

`define DPR_OFS_REMAP_EN     16'h033e
`define DPR_LOOKUP_BASE      16'h0340
`define DPR_OFS_MAP_06_07    16'h0343
`define DPR_OFS_MAP_08_09    16'h0344
`define DPR_OFS_MAP_0A_0B    16'h0345
`define DPR_OFS_MAP_0C_0D    16'h0346
`define DPR_OFS_MAP_0E_0F    16'h0347
`define DPR_OFS_MAP_10_11    16'h0348
`define DPR_OFS_MAP_12_13    16'h0349
`define DPR_OFS_MAP_14_15    16'h034a
`define DPR_OFS_MAP_16_17    16'h034b
`define DPR_OFS_MAP_18_19    16'h034c
`define DPR_OFS_MAP_1A_1B    16'h034d
`define DPR_OFS_MAP_1C_1D    16'h034e
`define DPR_OFS_MAP_1E_1F    16'h034f
`define DPR_OFS_MAP_20_21    16'h0350

`define DPR_MAP_COUNT        14
`define DPR_LO_MSB           2
`define DPR_LO_LSB           0
`define DPR_HI_MSB           6
`define DPR_HI_LSB           4
`define DPR_EN_BIT           0
`define DPR_MAP_RW_MASK      8'h77
`define DPR_PRIO_RESET       3'h0
`define DPR_EN_RESET         1'h0
`define DPR_BYPASS_MSB       5
`define DPR_BYPASS_LSB       3

`endif

// ---- include/dpr_pkg.sv ----
// Purpose: shared types of the dscp priority remap table
// Assumes: constants live in dpr_regs.svh
// Notes:   types only
package dpr_pkg;
    typedef logic [15:0] dpr_addr_type;
    typedef logic [7:0]  dpr_byte_type;
    typedef logic [5:0]  dpr_dscp_type;
    typedef logic [2:0]  dpr_prio_type;
    typedef logic [3:0]  dpr_idx_type;
endpackage

// ---- design/dpr_remap_table.sv ----
// Purpose: dscp to internal priority remap registers for codes 0x06..0x21
// Assumes: one clock, classifier inputs on the same clock
// Notes:   registered lookup, answer one cycle after the dscp strobe
`timescale 1ns/1ps
`include "dpr_regs.svh"

module dpr_remap_table
    import dpr_pkg::*;
(
    input  wire logic         i_core_clk,
    input  wire logic         i_sys_rst,
    input  wire dpr_addr_type i_reg_addr,
    input  wire dpr_byte_type i_reg_wdata,
    input  wire logic         i_reg_wr,
    input  wire logic         i_reg_rd,
    output dpr_byte_type      o_reg_rdata,
    output logic              o_reg_rvalid,
    input  wire dpr_dscp_type i_dscp,
    input  wire logic         i_dscp_valid,
    output dpr_prio_type      o_prio,
    output logic              o_prio_valid,
    output logic              o_prio_covered
);

    dpr_prio_type prio_lo_q [`DPR_MAP_COUNT];
    dpr_prio_type prio_hi_q [`DPR_MAP_COUNT];
    logic         remap_en_q;

    logic         wr_hit;
    dpr_idx_type  wr_idx;
    logic         rd_hit;
    dpr_idx_type  rd_idx;
    logic         lk_hit;
    dpr_idx_type  lk_idx;
    dpr_addr_type lk_addr;
    dpr_prio_type lk_prio;

    // one decoder shared by host writes, host reads and the classifier
    // lookup, so the three can never disagree on which byte is which
    function automatic logic [4:0] map_decode(input dpr_addr_type a);
        logic [4:0] r;
        r = 5'h00;
        if (a == `DPR_OFS_MAP_06_07) begin
            r = {1'b1, 4'h0};
        end else if (a == `DPR_OFS_MAP_08_09) begin
            r = {1'b1, 4'h1};
        end else if (a == `DPR_OFS_MAP_0A_0B) begin
            r = {1'b1, 4'h2};
        end else if (a == `DPR_OFS_MAP_0C_0D) begin
            r = {1'b1, 4'h3};
        end else if (a == `DPR_OFS_MAP_0E_0F) begin
            r = {1'b1, 4'h4};
        end else if (a == `DPR_OFS_MAP_10_11) begin
            r = {1'b1, 4'h5};
        end else if (a == `DPR_OFS_MAP_12_13) begin
            r = {1'b1, 4'h6};
        end else if (a == `DPR_OFS_MAP_14_15) begin
            r = {1'b1, 4'h7};
        end else if (a == `DPR_OFS_MAP_16_17) begin
            r = {1'b1, 4'h8};
        end else if (a == `DPR_OFS_MAP_18_19) begin
            r = {1'b1, 4'h9};
        end else if (a == `DPR_OFS_MAP_1A_1B) begin
            r = {1'b1, 4'ha};
        end else if (a == `DPR_OFS_MAP_1C_1D) begin
            r = {1'b1, 4'hb};
        end else if (a == `DPR_OFS_MAP_1E_1F) begin
            r = {1'b1, 4'hc};
        end else if (a == `DPR_OFS_MAP_20_21) begin
            r = {1'b1, 4'hd};
        end
        return r;
    endfunction

    always_comb begin
        {wr_hit, wr_idx} = map_decode(i_reg_addr);
        {rd_hit, rd_idx} = map_decode(i_reg_addr);
    end

    // lookup address: each pair of codes shares one table byte, picked by i_dscp[5:1]
    always_comb begin
        lk_addr = `DPR_LOOKUP_BASE + {11'h000, i_dscp[5:1]};
        {lk_hit, lk_idx} = map_decode(lk_addr);
    end

    // only bits 6:4 and 2:0 have storage, so reserved bits cannot stick
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            for (int i = 0; i < `DPR_MAP_COUNT; i++) begin
                prio_lo_q[i] <= `DPR_PRIO_RESET;
                prio_hi_q[i] <= `DPR_PRIO_RESET;
            end
        end else if (i_reg_wr && wr_hit) begin
            prio_lo_q[wr_idx] <=
                i_reg_wdata[`DPR_LO_MSB:`DPR_LO_LSB];
            prio_hi_q[wr_idx] <=
                i_reg_wdata[`DPR_HI_MSB:`DPR_HI_LSB];
        end
    end

    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            remap_en_q <= `DPR_EN_RESET;
        end else if (i_reg_wr && i_reg_addr == `DPR_OFS_REMAP_EN) begin
            remap_en_q <= i_reg_wdata[`DPR_EN_BIT];
        end
    end

    // read data stand for exactly one cycle, zero otherwise
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_reg_rdata  <= 8'h00;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (!i_reg_rd) begin
                o_reg_rdata <= 8'h00;
            end else if (i_reg_addr == `DPR_OFS_REMAP_EN) begin
                o_reg_rdata <= {7'h00, remap_en_q};
            end else if (rd_hit) begin
                o_reg_rdata <= {1'b0, prio_hi_q[rd_idx],
                                1'b0, prio_lo_q[rd_idx]};
            end else begin
                o_reg_rdata <= 8'h00;
            end
        end
    end

    // table reads straight from the flops, so a write is seen next cycle
    always_comb begin
        if (!lk_hit) begin
            lk_prio = `DPR_PRIO_RESET;
        end else if (i_dscp[0]) begin
            lk_prio = prio_hi_q[lk_idx];
        end else begin
            lk_prio = prio_lo_q[lk_idx];
        end
    end

    // with remap enabled, codes outside this bank answer zero and drop o_prio_covered;
    // a neighbouring bank is expected to supply those
    always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            o_prio         <= `DPR_PRIO_RESET;
            o_prio_valid   <= 1'b0;
            o_prio_covered <= 1'b0;
        end else begin
            o_prio_valid <= i_dscp_valid;
            if (!i_dscp_valid) begin
                o_prio         <= `DPR_PRIO_RESET;
                o_prio_covered <= 1'b0;
            end else if (!remap_en_q) begin
                o_prio <= i_dscp[`DPR_BYPASS_MSB:`DPR_BYPASS_LSB];
                o_prio_covered <= 1'b1;
            end else begin
                o_prio         <= lk_prio;
                o_prio_covered <= lk_hit;
            end
        end
    end

    property p_reserved_zero;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        o_reg_rvalid |-> (o_reg_rdata[7] == 1'b0 && o_reg_rdata[3] == 1'b0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bit read as one");

    property p_read_window;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        !o_reg_rvalid |-> o_reg_rdata == 8'h00;
    endproperty
    a_read_window: assert property (p_read_window)
        else $error("read data outside its cycle");

    property p_map_0343_rw;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_reg_wr && i_reg_addr == `DPR_OFS_MAP_06_07)
        ##1 (i_reg_rd && i_reg_addr == `DPR_OFS_MAP_06_07 && !i_reg_wr)
        |=> o_reg_rdata == ($past(i_reg_wdata, 2) & `DPR_MAP_RW_MASK);
    endproperty
    a_map_0343_rw: assert property (p_map_0343_rw)
        else $error("0x0343 readback wrong");

    property p_bypass;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_dscp_valid && !remap_en_q)
        |=> (o_prio_valid && o_prio == $past(i_dscp[5:3]));
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass priority wrong");

    property p_enable_write;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_reg_wr && i_reg_addr == `DPR_OFS_REMAP_EN)
        |=> remap_en_q == $past(i_reg_wdata[0]);
    endproperty
    a_enable_write: assert property (p_enable_write)
        else $error("remap enable not written");

    property p_hi_after_write;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_reg_wr && i_reg_addr == `DPR_OFS_MAP_08_09)
        ##1 (i_dscp_valid && i_dscp == 6'h09 && remap_en_q && !i_reg_wr)
        |=> o_prio == $past(i_reg_wdata[6:4], 2);
    endproperty
    a_hi_after_write: assert property (p_hi_after_write)
        else $error("upper field not used next cycle");

    property p_lo_after_write;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_reg_wr && i_reg_addr == `DPR_OFS_MAP_0A_0B)
        ##1 (i_dscp_valid && i_dscp == 6'h0a && remap_en_q && !i_reg_wr)
        |=> o_prio == $past(i_reg_wdata[2:0], 2);
    endproperty
    a_lo_after_write: assert property (p_lo_after_write)
        else $error("lower field not used next cycle");

    property p_uncovered;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_dscp_valid && remap_en_q && (i_dscp < 6'h06 || i_dscp > 6'h21))
        |=> (!o_prio_covered && o_prio == 3'h0);
    endproperty
    a_uncovered: assert property (p_uncovered)
        else $error("code outside bank claimed");

    property p_unmapped_read;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_reg_rd && (i_reg_addr < `DPR_OFS_MAP_06_07
                      || i_reg_addr > `DPR_OFS_MAP_20_21)
                  && i_reg_addr != `DPR_OFS_REMAP_EN)
        |=> o_reg_rvalid && o_reg_rdata == 8'h00;
    endproperty
    a_unmapped_read: assert property (p_unmapped_read)
        else $error("unmapped address read non-zero");

    // one check per table byte except 0x0343: a decode slip to a neighbour shows here
    property p_map_08_09;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_dscp_valid && remap_en_q && i_dscp[5:1] == 5'h04)
        |=> o_prio == ($past(i_dscp[0]) ? $past(prio_hi_q[1])
                                        : $past(prio_lo_q[1]));
    endproperty
    a_map_08_09: assert property (p_map_08_09)
        else $error("0x0344 lookup wrong");

    property p_map_0a_0b;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_dscp_valid && remap_en_q && i_dscp[5:1] == 5'h05)
        |=> o_prio == ($past(i_dscp[0]) ? $past(prio_hi_q[2])
                                        : $past(prio_lo_q[2]));
    endproperty
    a_map_0a_0b: assert property (p_map_0a_0b)
        else $error("0x0345 lookup wrong");

    property p_map_0c_0d;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_dscp_valid && remap_en_q && i_dscp[5:1] == 5'h06)
        |=> o_prio == ($past(i_dscp[0]) ? $past(prio_hi_q[3])
                                        : $past(prio_lo_q[3]));
    endproperty
    a_map_0c_0d: assert property (p_map_0c_0d)
        else $error("0x0346 lookup wrong");

    property p_map_0e_0f;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_dscp_valid && remap_en_q && i_dscp[5:1] == 5'h07)
        |=> o_prio == ($past(i_dscp[0]) ? $past(prio_hi_q[4])
                                        : $past(prio_lo_q[4]));
    endproperty
    a_map_0e_0f: assert property (p_map_0e_0f)
        else $error("0x0347 lookup wrong");

    property p_map_10_11;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_dscp_valid && remap_en_q && i_dscp[5:1] == 5'h08)
        |=> o_prio == ($past(i_dscp[0]) ? $past(prio_hi_q[5])
                                        : $past(prio_lo_q[5]));
    endproperty
    a_map_10_11: assert property (p_map_10_11)
        else $error("0x0348 lookup wrong");

    property p_map_12_13;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_dscp_valid && remap_en_q && i_dscp[5:1] == 5'h09)
        |=> o_prio == ($past(i_dscp[0]) ? $past(prio_hi_q[6])
                                        : $past(prio_lo_q[6]));
    endproperty
    a_map_12_13: assert property (p_map_12_13)
        else $error("0x0349 lookup wrong");

    property p_map_14_15;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_dscp_valid && remap_en_q && i_dscp[5:1] == 5'h0a)
        |=> o_prio == ($past(i_dscp[0]) ? $past(prio_hi_q[7])
                                        : $past(prio_lo_q[7]));
    endproperty
    a_map_14_15: assert property (p_map_14_15)
        else $error("0x034a lookup wrong");

    property p_map_16_17;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_dscp_valid && remap_en_q && i_dscp[5:1] == 5'h0b)
        |=> o_prio == ($past(i_dscp[0]) ? $past(prio_hi_q[8])
                                        : $past(prio_lo_q[8]));
    endproperty
    a_map_16_17: assert property (p_map_16_17)
        else $error("0x034b lookup wrong");

    property p_map_18_19;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_dscp_valid && remap_en_q && i_dscp[5:1] == 5'h0c)
        |=> o_prio == ($past(i_dscp[0]) ? $past(prio_hi_q[9])
                                        : $past(prio_lo_q[9]));
    endproperty
    a_map_18_19: assert property (p_map_18_19)
        else $error("0x034c lookup wrong");

    property p_map_1a_1b;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_dscp_valid && remap_en_q && i_dscp[5:1] == 5'h0d)
        |=> o_prio == ($past(i_dscp[0]) ? $past(prio_hi_q[10])
                                        : $past(prio_lo_q[10]));
    endproperty
    a_map_1a_1b: assert property (p_map_1a_1b)
        else $error("0x034d lookup wrong");

    property p_map_1c_1d;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_dscp_valid && remap_en_q && i_dscp[5:1] == 5'h0e)
        |=> o_prio == ($past(i_dscp[0]) ? $past(prio_hi_q[11])
                                        : $past(prio_lo_q[11]));
    endproperty
    a_map_1c_1d: assert property (p_map_1c_1d)
        else $error("0x034e lookup wrong");

    property p_map_1e_1f;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_dscp_valid && remap_en_q && i_dscp[5:1] == 5'h0f)
        |=> o_prio == ($past(i_dscp[0]) ? $past(prio_hi_q[12])
                                        : $past(prio_lo_q[12]));
    endproperty
    a_map_1e_1f: assert property (p_map_1e_1f)
        else $error("0x034f lookup wrong");

    property p_map_20_21;
        @(posedge i_core_clk) disable iff (i_sys_rst)
        (i_dscp_valid && remap_en_q && i_dscp[5:1] == 5'h10)
        |=> o_prio == ($past(i_dscp[0]) ? $past(prio_hi_q[13])
                                        : $past(prio_lo_q[13]));
    endproperty
    a_map_20_21: assert property (p_map_20_21)
        else $error("0x0350 lookup wrong");

    c_uncovered: cover property (@(posedge i_core_clk)
        disable iff (i_sys_rst) o_prio_valid && !o_prio_covered);
    c_write_then_read: cover property (@(posedge i_core_clk)
        disable iff (i_sys_rst) i_reg_wr ##1 i_reg_rd);
    c_remap_hit: cover property (@(posedge i_core_clk)
        disable iff (i_sys_rst) o_prio_valid && o_prio_covered
        && o_prio != 3'h0 && remap_en_q);
    c_bypass: cover property (@(posedge i_core_clk)
        disable iff (i_sys_rst) o_prio_valid && !remap_en_q);
    c_readback: cover property (@(posedge i_core_clk)
        disable iff (i_sys_rst) o_reg_rvalid && o_reg_rdata != 8'h00);

endmodule // dpr_remap_table

// ---- test/dpr_remap_table_bench.sv ----
// Purpose: self-checking bench for the dscp priority remap table
// Assumes: bench drives every port itself, one clock at 200 MHz
// Notes:   inputs change by non-blocking assignment at the rising edge
`timescale 1ns/1ps
`include "dpr_regs.svh"
module dpr_remap_table_bench
    import dpr_pkg::*;
;
    logic         core_clk     = 1'b0;
    logic         sys_rst      = 1'b1;
    dpr_addr_type reg_addr     = 16'h0000;
    dpr_byte_type reg_wdata    = 8'h00;
    logic         reg_wr       = 1'b0;
    logic         reg_rd       = 1'b0;
    dpr_byte_type reg_rdata;
    logic         reg_rvalid;
    dpr_dscp_type dscp         = 6'h00;
    logic         dscp_valid   = 1'b0;
    dpr_prio_type prio;
    logic         prio_valid;
    logic         prio_covered;
    int           err_total    = 0;
    int           total_checks = 0;

    always #2.5 core_clk = ~core_clk;

    dpr_remap_table dpr_remap_table_inst (
        .i_core_clk    (core_clk),
        .i_sys_rst     (sys_rst),
        .i_reg_addr    (reg_addr),
        .i_reg_wdata   (reg_wdata),
        .i_reg_wr      (reg_wr),
        .i_reg_rd      (reg_rd),
        .o_reg_rdata   (reg_rdata),
        .o_reg_rvalid  (reg_rvalid),
        .i_dscp        (dscp),
        .i_dscp_valid  (dscp_valid),
        .o_prio        (prio),
        .o_prio_valid  (prio_valid),
        .o_prio_covered(prio_covered)
    );

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk_byte(input dpr_byte_type got, input dpr_byte_type exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: byte %h, want %h", $time, got, exp);
        end
    endtask

    task automatic chk_prio(input dpr_prio_type got, input dpr_prio_type exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: prio %h, want %h", $time, got, exp);
        end
    endtask

    task automatic chk_flag(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            err_total++;
            $display("mismatch at %0t: flag %b, want %b", $time, got, exp);
        end
    endtask

    task automatic do_reset();
        sys_rst <= 1'b1;
        repeat (5) @(posedge core_clk);
        sys_rst <= 1'b0;
    endtask

    task automatic reg_write(input dpr_addr_type a, input dpr_byte_type d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr    <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe, so sample there
    task automatic reg_check(input dpr_addr_type a, input dpr_byte_type exp);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd   <= 1'b0;
        #1;
        chk_flag(reg_rvalid, 1'b1);
        chk_byte(reg_rdata, exp);
    endtask

    task automatic lk(input dpr_dscp_type d, input dpr_prio_type e,
                      input logic cov);
        @(posedge core_clk);
        dscp_valid <= 1'b1;
        dscp       <= d;
        @(posedge core_clk);
        dscp_valid <= 1'b0;
        #1;
        chk_flag(prio_valid, 1'b1);
        chk_prio(prio, e);
        chk_flag(prio_covered, cov);
    endtask

    task automatic t_reset_values();
        for (int i = 0; i < `DPR_MAP_COUNT; i++) begin
            reg_check(`DPR_OFS_MAP_06_07 + 16'(i), 8'h00);
        end
        reg_check(`DPR_OFS_REMAP_EN, 8'h00);
        lk(6'h2a, 3'h5, 1'b1);
        $display("test reset_values done");
    endtask

    task automatic t_field_access();
        for (int i = 0; i < `DPR_MAP_COUNT; i++) begin
            reg_write(`DPR_OFS_MAP_06_07 + 16'(i), 8'hff);
            reg_check(`DPR_OFS_MAP_06_07 + 16'(i), 8'h77);
            reg_write(`DPR_OFS_MAP_06_07 + 16'(i), 8'h88);
            reg_check(`DPR_OFS_MAP_06_07 + 16'(i), 8'h00);
        end
        reg_write(`DPR_OFS_REMAP_EN, 8'hff);
        reg_check(`DPR_OFS_REMAP_EN, 8'h01);
        reg_write(16'h0351, 8'hff);
        reg_check(16'h0351, 8'h00);
        $display("test field_access done");
    endtask

    // reserved bits are set on purpose so a leak into a field shows
    task automatic t_map(input int lo, input int hi);
        reg_write(`DPR_OFS_REMAP_EN, 8'h01);
        for (int i = lo; i <= hi; i++) begin
            reg_write(`DPR_OFS_MAP_06_07 + 16'(i),
                      {1'b1, ~3'(i), 1'b1, 3'(i)});
        end
        for (int i = lo; i <= hi; i++) begin
            lk(6'(6 + 2 * i), 3'(i), 1'b1);
            lk(6'(7 + 2 * i), ~3'(i), 1'b1);
        end
        lk(6'h05, 3'h0, 1'b0);
        lk(6'h22, 3'h0, 1'b0);
        $display("test map %0d..%0d done", lo, hi);
    endtask

    task automatic t_bypass();
        reg_write(`DPR_OFS_REMAP_EN, 8'h00);
        for (int d = 0; d < 64; d += 9) begin
            lk(6'(d), 3'(d >> 3), 1'b1);
        end
        @(posedge core_clk);
        #1;
        chk_flag(prio_valid, 1'b0);
        $display("test bypass done");
    endtask

    // write, read-back and lookup taken on adjacent edges
    task automatic t_write_use();
        reg_write(`DPR_OFS_REMAP_EN, 8'h01);
        @(posedge core_clk);
        reg_wr     <= 1'b1;
        reg_addr   <= `DPR_OFS_MAP_08_09;
        reg_wdata  <= 8'h53;
        @(posedge core_clk);
        reg_wr     <= 1'b0;
        reg_rd     <= 1'b1;
        dscp_valid <= 1'b1;
        dscp       <= 6'h09;
        @(posedge core_clk);
        reg_rd     <= 1'b0;
        dscp_valid <= 1'b0;
        #1;
        chk_byte(reg_rdata, 8'h53);
        chk_prio(prio, 3'h5);
        @(posedge core_clk);
        reg_wr     <= 1'b1;
        reg_addr   <= `DPR_OFS_MAP_0A_0B;
        reg_wdata  <= 8'h36;
        @(posedge core_clk);
        reg_wr     <= 1'b0;
        dscp_valid <= 1'b1;
        dscp       <= 6'h0a;
        @(posedge core_clk);
        dscp_valid <= 1'b0;
        reg_wr     <= 1'b1;
        reg_addr   <= `DPR_OFS_MAP_06_07;
        reg_wdata  <= 8'hf5;
        #1;
        chk_prio(prio, 3'h6);
        @(posedge core_clk);
        reg_wr     <= 1'b0;
        reg_rd     <= 1'b1;
        @(posedge core_clk);
        reg_rd     <= 1'b0;
        #1;
        chk_byte(reg_rdata, 8'h75);
        $display("test write_use done");
    endtask

    task automatic t_reset_again();
        reg_write(`DPR_OFS_MAP_20_21, 8'h77);
        do_reset();
        reg_check(`DPR_OFS_MAP_20_21, 8'h00);
        reg_check(`DPR_OFS_REMAP_EN, 8'h00);
        $display("test reset_again done");
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        err_total++;
        $display("mismatch at %0t: watchdog expired", $time);
        stop_test();
    end

    initial begin
        do_reset();
        t_reset_values();
        t_field_access();
        t_map(0, 6);
        t_map(7, 13);
        t_bypass();
        t_write_use();
        t_reset_again();
        stop_test();
    end
endmodule // dpr_remap_table_bench
